// ===== src/lbm_pkg.sv
// Package for the loopback and transmit indicator mux block.
// Assumes one 250 MHz core clock and an external E1 bit-rate enable.
package lbm_pkg;

	localparam int CLK_MHZ = 250;
	// Inband code hold time before auto loopback changes, in ms
	localparam int IB_HOLD_MS = 5100;
	localparam longint IB_HOLD_CYC = longint'(IB_HOLD_MS) * 1000 * CLK_MHZ;
	localparam int IB_CNT_W = 32;

	// Indicator select field position in transmit config register one
	localparam int IND_SEL_LSB = 5;
	localparam int IND_SEL_W = 3;

	// Status bit positions
	localparam int SYS_ALARM_BIT = 7;
	localparam int OVERCURRENT_BIT = 4;
	localparam int TX_LINE_LOSS_BIT = 2;
	localparam int SYS_LOSS_BIT = 1;
	localparam int AUTO_LOOP_STAT_BIT = 7;

	// Loop control bit positions
	localparam int ANALOG_LOOP_BIT = 0;
	localparam int REMOTE_LOOP_BIT = 1;
	localparam int DIGITAL_LOOP_BIT = 2;
	localparam int AUTO_LOOP_BIT = 3;

	localparam logic [1:0] BUF_DEPTH = 2'h2;

	typedef enum logic [2:0] {
		IND_PATTERN,
		IND_SYS_ALARM,
		IND_OVERCURRENT,
		IND_LINE_LOSS,
		IND_EXCESS_ZERO,
		IND_BIPOLAR,
		IND_COMBINED,
		IND_SYS_LOSS
	} lbm_ind_sel_t;

	typedef enum logic [1:0] {
		FMT_SINGLE_NRZ,
		FMT_DUAL_NRZ,
		FMT_DUAL_RZ
	} lbm_tx_fmt_t;

	// Priority choices of each path
	typedef enum logic [1:0] {
		SRC_NORMAL,
		SRC_PATTERN,
		SRC_LOOPED,
		SRC_AIS
	} lbm_src_t;

	// Transmit-path detector events and levels
	typedef struct packed {
		logic pat_sync;
		logic pat_err;
		logic excess_zero;
		logic bipolar;
	} lbm_tx_det_t;

	// Loop state word handed downstream
	typedef struct packed {
		logic analog;
		logic remote;
		logic digital;
		lbm_src_t rx_src;
		lbm_src_t tx_src;
	} lbm_loop_t;

endpackage

// ===== src/lbm_buf2.sv
// Two-entry valid/ready buffer carrying the loop state word.
// Assumes the drain side may stall at any time.
`timescale 1ns/1ps
module lbm_buf2
	import lbm_pkg::*;
#(
	parameter int W = 9
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_q [2];
	logic wr_q;
	logic rd_q;
	logic [1:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = cnt_q != BUF_DEPTH;
	assign out_valid = cnt_q != 2'h0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 2'h1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end
endmodule // lbm_buf2

// ===== src/lbm_top.sv
// Per-channel transmit indicator mux and loopback control.
// Assumes detectors upstream give levels and one-cycle event pulses,
// and e1_en marks one E1 bit period of the core clock.
`timescale 1ns/1ps
// Function
// - Negative-rail input pin becomes the indicator in single NRZ or dual RZ.
// - Config bits 7..5 select one of eight transmit indicator sources.
// - Single NRZ disables bipolar, combined and system loss choices.
// - Pattern: high in sync, low one E1 cycle per error, low unsynced.
// - System alarm choice follows status register one bit 7.
// - Over-current choice follows status bit 4.
// - Transmit line loss choice follows status bit 2.
// - Event choices pulse high one E1 cycle per event.
// - System loss choice follows status bit 1.
// - Analog loop bit 0 loops transmit output to receive input.
// - Analog loop disables remote and digital loops, manual and automatic.
// - Analog loop: receive pattern over looped data, no AIS anywhere.
// - Remote loop active on manual bit 1 or automatic engagement on receive codes.
// - Auto remote loop enters and leaves on receive codes over 5.1 s.
// - Clearing auto enable ends auto loop; status bit 7 shows engagement.
// - Remote loop: receive data looped to line, transmit detectors watch system.
// - Remote loop: receive pattern over AIS; transmit pattern over loop.
// - Digital loop on manual bit 2 or auto on transmit codes.
// - Digital loop: transmit data looped inward, line detectors watch line.
// - Digital loop: receive pattern over loop; transmit pattern, loop, AIS.
module lbm_top
	import lbm_pkg::*;
#(
	parameter longint IB_HOLD = IB_HOLD_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic e1_en,
	// Configuration
	input wire logic [7:0] tx_config_reg_one,
	input wire logic [3:0] loop_ctrl,
	input wire logic pattern_detect_position,
	input wire lbm_tx_fmt_t tx_format,
	input wire logic rx_pat_gen_en,
	input wire logic tx_pat_gen_en,
	input wire logic rx_ais_gen_en,
	input wire logic tx_ais_gen_en,
	// Status inputs
	input wire logic [7:0] status_reg_zero_in,
	input wire logic [7:0] status_reg_one,
	input wire lbm_tx_det_t tx_det,
	// Inband code detectors
	input wire logic rx_ib_activate,
	input wire logic rx_ib_deactivate,
	input wire logic tx_ib_activate,
	input wire logic tx_ib_deactivate,
	// Pin
	input wire logic tx_negative_rail_in,
	output logic tx_indicator_out,
	output logic tx_indicator_oe,
	output logic tx_negative_rail_data,
	// Loop state stream and status register zero
	output logic loop_valid,
	input wire logic loop_ready,
	output lbm_loop_t loop_state,
	output logic [7:0] status_reg_zero
);
	logic [IB_CNT_W-1:0] hold_cnt_q;
	logic auto_q;
	logic auto_dig_q;
	logic ind_q;
	logic pat_low_q;
	logic ev_q;
	logic analog_loop_enable;
	logic remote_loop_enable;
	logic digital_loop_enable;
	logic auto_loop_enable;
	logic auto_loop_status;
	logic want_code;
	logic ind_pin;
	logic ind_d;
	logic ev_now;
	lbm_ind_sel_t tx_indicator_select;
	lbm_loop_t loop_d;
	lbm_loop_t last_q;
	logic buf_in_ready;
	logic loop_change;
	logic hold_done;
	logic fmt_single_nrz;
	logic sel_reserved;
	logic ev_ez;
	logic ev_bpv;
	logic ev_comb;
	lbm_src_t rx_src;
	lbm_src_t tx_src;

	// Select field taken from config bits 7..5
	assign tx_indicator_select =
		lbm_ind_sel_t'(tx_config_reg_one[IND_SEL_LSB +: IND_SEL_W]);
	assign analog_loop_enable = loop_ctrl[ANALOG_LOOP_BIT];
	assign auto_loop_enable = loop_ctrl[AUTO_LOOP_BIT];

	// Pin role chosen by transmit format
	// Dual-rail NRZ keeps the pin as a data input
	assign ind_pin = tx_format != FMT_DUAL_NRZ;
	assign tx_indicator_oe = ind_pin;
	assign tx_indicator_out = ind_pin ? ind_q : 1'b0;
	assign tx_negative_rail_data = ind_pin ? 1'b0 : tx_negative_rail_in;

	// Status bit 7 carries auto engagement
	assign auto_loop_status = auto_q;
	// Input copy kept for the bits this block does not own
	always_comb begin
		status_reg_zero = status_reg_zero_in;
		status_reg_zero[AUTO_LOOP_STAT_BIT] = auto_loop_status;
	end

	// Watched code depends on current engagement
	// Position picks which path's code detector is watched
	assign want_code = pattern_detect_position
		? (auto_q ? tx_ib_deactivate : tx_ib_activate)
		: (auto_q ? rx_ib_deactivate : rx_ib_activate);

	// Code has stood longer than the hold time
	assign hold_done = want_code && hold_cnt_q > IB_CNT_W'(IB_HOLD);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hold_cnt_q <= '0;
		end else if (!auto_loop_enable || analog_loop_enable || !want_code) begin
			hold_cnt_q <= '0;
		end else if (hold_cnt_q <= IB_CNT_W'(IB_HOLD)) begin
			hold_cnt_q <= hold_cnt_q + 1'b1;
		end else begin
			hold_cnt_q <= '0;
		end
	end

	// Auto engagement, cleared by disabling auto
	// Disable wins over a code that completes in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			auto_q <= 1'b0;
		end else if (!auto_loop_enable) begin
			auto_q <= 1'b0;
		end else if (hold_done) begin
			auto_q <= ~auto_q;
		end
	end

	// Position latched at entry; host keeps it steady
	// Latching holds the loop type through a mid-loop position change; the exit code follows the live position
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			auto_dig_q <= 1'b0;
		end else if (auto_loop_enable && hold_done && !auto_q) begin
			auto_dig_q <= pattern_detect_position;
		end
	end

	// Remote loop from manual bit or auto
	assign remote_loop_enable = !analog_loop_enable
		&& (loop_ctrl[REMOTE_LOOP_BIT] || (auto_q && !auto_dig_q));
	// Digital loop from manual bit or auto
	assign digital_loop_enable = !analog_loop_enable
		&& (loop_ctrl[DIGITAL_LOOP_BIT] || (auto_q && auto_dig_q));

	always_comb begin
		if (rx_pat_gen_en) begin
			rx_src = SRC_PATTERN;
		end else if (analog_loop_enable || digital_loop_enable) begin
			// Looped data replaces line data, no AIS
			rx_src = SRC_LOOPED;
		end else if (rx_ais_gen_en) begin
			// Remote loop still sends AIS inward when enabled
			rx_src = SRC_AIS;
		end else begin
			rx_src = SRC_NORMAL;
		end
	end

	always_comb begin
		if (tx_pat_gen_en) begin
			tx_src = SRC_PATTERN;
		end else if (remote_loop_enable || digital_loop_enable) begin
			// Looped data ahead of transmit AIS
			tx_src = SRC_LOOPED;
		end else if (tx_ais_gen_en && !analog_loop_enable) begin
			tx_src = SRC_AIS;
		end else begin
			tx_src = SRC_NORMAL;
		end
	end

	// Loop word gathered for the downstream stream
	always_comb begin
		loop_d.analog = analog_loop_enable;
		loop_d.remote = remote_loop_enable;
		loop_d.digital = digital_loop_enable;
		loop_d.rx_src = rx_src;
		loop_d.tx_src = tx_src;
	end

	// New loop word offered only on change; buffer absorbs stalls
	assign loop_change = loop_d != last_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			last_q <= '0;
		end else if (buf_in_ready && loop_change) begin
			last_q <= loop_d;
		end
	end

	// Two entries hold two loop changes for a stalled sink; while full, only the newest word waits
	lbm_buf2 #(
		.W($bits(lbm_loop_t))
	) u_buf (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(loop_change),
		.in_ready(buf_in_ready),
		.in_data(loop_d),
		.out_valid(loop_valid),
		.out_ready(loop_ready),
		.out_data(loop_state)
	);

	// Events that match the chosen source
	assign ev_ez = tx_indicator_select == IND_EXCESS_ZERO
		&& tx_det.excess_zero;
	assign ev_bpv = tx_indicator_select == IND_BIPOLAR && tx_det.bipolar;
	assign ev_comb = tx_indicator_select == IND_COMBINED
		&& (tx_det.bipolar || tx_det.excess_zero);
	assign ev_now = ev_ez || ev_bpv || ev_comb;

	// Event pulse held until the E1 period ends
	// A new event in the clearing cycle wins, so none is lost
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ev_q <= 1'b0;
		end else if (ev_now) begin
			ev_q <= 1'b1;
		end else if (e1_en) begin
			ev_q <= 1'b0;
		end
	end

	// Error drops pattern indication one E1 cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pat_low_q <= 1'b0;
		end else if (tx_det.pat_err) begin
			pat_low_q <= 1'b1;
		end else if (e1_en) begin
			pat_low_q <= 1'b0;
		end
	end

	// Choices that single-rail NRZ cannot carry
	assign fmt_single_nrz = tx_format == FMT_SINGLE_NRZ;
	assign sel_reserved = fmt_single_nrz
		&& (tx_indicator_select == IND_BIPOLAR
		|| tx_indicator_select == IND_COMBINED
		|| tx_indicator_select == IND_SYS_LOSS);

	always_comb begin
		unique case (tx_indicator_select)
			IND_PATTERN: ind_d = tx_det.pat_sync && !pat_low_q;
			IND_SYS_ALARM: ind_d = status_reg_one[SYS_ALARM_BIT];
			IND_OVERCURRENT: ind_d = status_reg_zero_in[OVERCURRENT_BIT];
			IND_LINE_LOSS: ind_d = status_reg_zero_in[TX_LINE_LOSS_BIT];
			IND_EXCESS_ZERO: ind_d = ev_q;
			IND_BIPOLAR: ind_d = ev_q;
			IND_COMBINED: ind_d = ev_q;
			IND_SYS_LOSS: ind_d = status_reg_zero_in[SYS_LOSS_BIT];
		endcase
		if (sel_reserved) begin
			ind_d = 1'b0;
		end
	end

	// Registered so the pin sees no decode glitches
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ind_q <= 1'b0;
		end else begin
			ind_q <= ind_d;
		end
	end
endmodule // lbm_top

// ===== sim/lbm_properties.sv
// Port checker for the indicator mux and loop control.
// Assumes lbm_top ports; attached by the bind at the foot.
`timescale 1ns/1ps
module lbm_checker
	import lbm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Watched ports
	input wire logic [7:0] tx_config_reg_one,
	input wire logic [3:0] loop_ctrl,
	input wire lbm_tx_fmt_t tx_format,
	input wire logic [7:0] status_reg_zero_in,
	input wire logic [7:0] status_reg_one,
	input wire lbm_tx_det_t tx_det,
	input wire logic tx_indicator_out,
	input wire logic tx_indicator_oe,
	input wire logic loop_valid,
	input wire lbm_loop_t loop_state,
	input wire logic [7:0] status_reg_zero
);
	logic run_q;
	logic [2:0] psel_q;
	lbm_tx_fmt_t pfmt_q;
	logic [2:0] sel;
	logic st;
	assign sel = tx_config_reg_one[7:5];
	// Registered output: only judge once the choice has held a cycle
	assign st = run_q && sel == psel_q && tx_format == pfmt_q && tx_indicator_oe;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
			psel_q <= 3'h0;
			pfmt_q <= FMT_SINGLE_NRZ;
		end else begin
			run_q <= 1'b1;
			psel_q <= sel;
			pfmt_q <= tx_format;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_oe_format: assert property (tx_indicator_oe ==
		(tx_format != FMT_DUAL_NRZ)) else $error("oe wrong");
	a_nrz_reserved: assert property (st && sel >= 3'h5 &&
		tx_format == FMT_SINGLE_NRZ |-> !tx_indicator_out) else $error("nrz");
	a_alarm_level: assert property (st && sel == 3'h1 |->
		tx_indicator_out == $past(status_reg_one[7])) else $error("alarm");
	a_overcur_level: assert property (st && sel == 3'h2 |->
		tx_indicator_out == $past(status_reg_zero_in[4])) else $error("oc");
	a_line_loss: assert property (st && sel == 3'h3 |->
		tx_indicator_out == $past(status_reg_zero_in[2])) else $error("tx_line_loss");
	a_sys_loss: assert property (st && sel == 3'h7 &&
		tx_format != FMT_SINGLE_NRZ |->
		tx_indicator_out == $past(status_reg_zero_in[1])) else $error("system_side_loss");
	a_event_pulse: assert property (st && sel == 3'h4 &&
		tx_det.excess_zero |-> ##2 tx_indicator_out) else $error("event");
	a_analog_excl: assert property (loop_valid && loop_state.analog |->
		!loop_state.remote && !loop_state.digital) else $error("analog");
	a_auto_clear: assert property (!loop_ctrl[3] [*2] |->
		!status_reg_zero[7]) else $error("auto status");
endmodule // lbm_checker
bind lbm_top lbm_checker lbm_checker_i (.*);

// ===== sim/lbm_sys_model.sv
// System-side framer stand-in: detector events and loop word sink.
// Assumes the bench steers it through plain command pins.
`timescale 1ns/1ps
module lbm_sys_model
	import lbm_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Bench commands
	input wire logic [2:0] fire,
	input wire logic sync,
	input wire logic stall,
	// Toward the block
	output lbm_tx_det_t tx_det,
	output logic loop_ready
);
	// Events last one clock, as real detectors give them
	always_ff @(posedge core_clk) begin
		tx_det <= {sync, fire};
	end
	assign loop_ready = !stall;
endmodule // lbm_sys_model

// ===== sim/tb.sv
// Self-checking bench for lbm_top with a short inband hold.
// Assumes lbm_sys_model as system side and the bound checker.
`timescale 1ns/1ps
module tb;
	import lbm_pkg::*;
	logic core_clk, rst, e1_en, pdp, stall, sync, rail, h;
	logic [7:0] cfg, sz_in, s_one, sz;
	logic [3:0] ctrl, gen, ib;
	logic [2:0] fire;
	lbm_tx_fmt_t fmt;
	lbm_tx_det_t det;
	lbm_loop_t ls, w;
	logic ind, oe, ndata, lv, lr;
	int mismatches, n_compared, i, k, e1c = 0;
	int sl[4] = '{1, 2, 3, 7};
	int bt[4] = '{7, 4, 2, 1};
	logic [14:0] rows[6] = '{15'h3CC4, 15'h09C8, 15'h17A5, 15'h11AE,
		15'h219A, 15'h2615};
	lbm_top #(.IB_HOLD(20)) lbm_top_i (.core_clk(core_clk), .rst(rst),
		.e1_en(e1_en), .tx_config_reg_one(cfg), .loop_ctrl(ctrl),
		.pattern_detect_position(pdp), .tx_format(fmt),
		.rx_pat_gen_en(gen[3]), .tx_pat_gen_en(gen[2]),
		.rx_ais_gen_en(gen[1]), .tx_ais_gen_en(gen[0]),
		.status_reg_zero_in(sz_in), .status_reg_one(s_one), .tx_det(det),
		.rx_ib_activate(ib[3]), .rx_ib_deactivate(ib[2]),
		.tx_ib_activate(ib[1]), .tx_ib_deactivate(ib[0]),
		.tx_negative_rail_in(rail), .tx_indicator_out(ind),
		.tx_indicator_oe(oe), .tx_negative_rail_data(ndata),
		.loop_valid(lv), .loop_ready(lr), .loop_state(ls),
		.status_reg_zero(sz));
	lbm_sys_model lbm_sys_model_i (.core_clk(core_clk), .fire(fire),
		.sync(sync), .stall(stall), .tx_det(det), .loop_ready(lr));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// E1 bit period of eight core clocks
	always @(negedge core_clk) begin
		e1c <= (e1c + 1) % 8;
		e1_en <= (e1c == 7);
	end
	task automatic give_verdict();
		if (mismatches == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic pulse(logic [2:0] f);
		fire = f;
		cyc(1);
		fire = 3'h0;
	endtask
	// Bounded wait on the indicator or the auto status bit
	task automatic seek(string n, bit a, logic v, int lim);
		for (int j = 0; j < lim && (a ? sz[7] : ind) !== v; j++)
			cyc(1);
		chk(n, v, a ? sz[7] : ind);
		if ((a ? sz[7] : ind) !== v) give_verdict();
	endtask
	// Keeps the newest word the sink accepted
	task automatic last_word();
		repeat (12) begin
			cyc(1);
			if (lv && lr) w = ls;
		end
	endtask
	initial begin
		rst = 1'b1;
		{cfg, ctrl, pdp, gen, sz_in, s_one} = '0;
		{ib, rail, fire, sync, stall, w} = '0;
		fmt = FMT_DUAL_RZ;
		mismatches = 0;
		n_compared = 0;
		repeat (16) @(posedge core_clk);
		cyc(1);
		rst = 1'b0;
		for (i = 0; i < 3; i++) begin
			fmt = lbm_tx_fmt_t'(i);
			rail = 1'b1;
			cyc(2);
			chk("oe", 8'(i != 1), oe);
			chk("rail", 8'(i == 1), ndata);
		end
		fmt = FMT_DUAL_RZ;
		for (i = 0; i < 4; i++) begin
			cfg = 8'(sl[i] << 5);
			for (k = 1; k >= 0; k--) begin
				if (i == 0) s_one[7] = k[0];
				else sz_in[bt[i]] = k[0];
				cyc(3);
				chk("level", 8'(k), ind);
				chk("stat_copy", sz_in, sz);
			end
		end
		fmt = FMT_SINGLE_NRZ;
		cfg = 8'hE0;
		sz_in[1] = 1'b1;
		cyc(3);
		chk("nrz_sys_loss", 0, ind);
		sz_in[1] = 1'b0;
		for (i = 0; i < 12; i++) begin
			fmt = i < 6 ? FMT_DUAL_RZ : FMT_SINGLE_NRZ;
			k = 4 + i % 6 / 2;
			cfg = 8'(k << 5);
			cyc(2);
			pulse(i[0] ? 3'h1 : 3'h2);
			h = 1'b0;
			repeat (6) begin
				cyc(1);
				h = h | ind;
			end
			chk("event", 8'((k == 4 && !i[0]) || (i < 6 && (k == 6 ||
				(k == 5 && i[0])))), h);
			cyc(10);
			chk("event_end", 0, ind);
		end
		fmt = FMT_DUAL_RZ;
		cfg = 8'h00;
		sync = 1'b1;
		cyc(3);
		chk("pat_sync", 1, ind);
		pulse(3'h4);
		seek("pat_err", 0, 0, 6);
		seek("pat_back", 0, 1, 12);
		sync = 1'b0;
		cyc(3);
		chk("pat_unsync", 0, ind);
		for (i = 0; i < 6; i++) begin
			{ctrl, gen} = rows[i][14:7];
			stall = (i == 3);
			last_word();
			if (i == 3) chk("held", 1, lv);
			else chk("loop_word", rows[i][6:0], w);
		end
		{ctrl, gen, ib} = 12'h808;
		cyc(18);
		chk("auto_early", 0, sz[7]);
		seek("auto_on", 1, 1, 12);
		last_word();
		chk("auto_remote", 1, w.remote);
		ib = 4'h4;
		seek("auto_off", 1, 0, 40);
		ib = 4'h8;
		seek("auto_again", 1, 1, 40);
		ctrl = 4'h0;
		cyc(2);
		chk("auto_cleared", 0, sz[7]);
		ib = 4'h0;
		cyc(2);
		pdp = 1'b1;
		{ctrl, ib} = 8'h82;
		seek("auto_dig", 1, 1, 40);
		last_word();
		chk("auto_digital", 1, w.digital);
		ctrl = 4'h9;
		last_word();
		chk("analog_wins", 8'h48, w);
		give_verdict();
	end
endmodule // tb
